// File: core/grp_mon.sv
// Group address filter and communication error monitor of a motor driver.
// Assumes a frame front end on SYS_CLK and an asynchronous baud switch.
//
// Behaviour
// - Only parent responds to group query
// - Child executes queries to group address
// - Parent treats group query as unicast
// - Group register: -1 or 1 to 31
// - Group setting never saved, volatile
// - Group reception executes only function 10h
// - Errors logged in volatile readable history
// - Codes 84h, 88h, 89h
// - Codes 8Ah, 8Ch, 8Dh
// - Alarm: fault output off, stop, blink
// - Warning sets caution, clears with cause
// - Baud switch 8 to F is error
// - One transmit error warns, good frame clears
// - Consecutive errors reaching count raise alarm
// - Silence past timeout raises alarm 85h
// - Timeout 0 to 10000 ms, immediate
// - Error count 1 to 10, immediate
`timescale 1ns/1ps
`default_nettype none
module grp_mon (
  // Clock and reset
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST,
  // Frame reports and executor results
  input  wire grp_mon_pkg::frame_t  FRAME,
  input  wire logic [7:0]           OWN_ADDR,
  input  wire grp_mon_pkg::exc_t    EXEC_EXC,
  // Register write/read port (unicast only)
  input  wire logic                 REG_WR,
  input  wire logic [15:0]          REG_ADDR,
  input  wire logic [15:0]          REG_WDATA,
  output logic [15:0]               REG_RDATA,
  output logic                      REG_ERR,
  // Parameters, immediate effect
  input  wire logic [15:0]          TIMEOUT_MS,
  input  wire logic [3:0]           ERR_ALARM_CNT,
  // History read
  input  wire logic [3:0]           HIST_IDX,
  output logic [7:0]                HIST_CODE,
  // Baud select switch pins
  input  wire logic [3:0]           BAUD_SELECT_SWITCH,
  // Frame decision
  output logic                      EXECUTE,
  output logic                      RESPOND,
  // Status outputs
  output logic                      FAULT_FREE_OUTPUT,
  output logic                      CAUTION_OUTPUT,
  output logic                      MOTOR_STOP,
  output logic                      ALARM_BLINK,
  output logic [7:0]                ALARM_CODE
);
  logic [31:0] group_q;
  logic [15:0] hi_stage_q;
  logic [3:0]  sw1_q, sw2_q, sw3_q, sw_q;
  logic [3:0]  run_q;
  logic [23:0] ms_q;
  logic [15:0] idle_ms_q;
  logic        warn_q, alarm_q;
  logic [7:0]  alarm_code_q;
  logic [7:0]  hist_q [grp_mon_pkg::HIST_DEPTH];
  logic [3:0]  hist_wp_q;
  logic        own_hit, grp_hit, good, bad, log_en, sw_bad;
  logic [7:0]  log_code;
  logic [3:0]  limit;
  logic [31:0] grp_new;

  // Address match; group membership only when not -1
  assign own_hit = FRAME.addr == OWN_ADDR;
  assign grp_hit = group_q != grp_mon_pkg::GROUP_NONE &&
                   FRAME.addr == group_q[7:0];
  assign good = FRAME.valid && FRAME.crc_ok;
  assign bad  = FRAME.valid && !FRAME.crc_ok;
  assign grp_new = {hi_stage_q, REG_WDATA};

  // Execute/respond decisions, registered
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      EXECUTE <= 1'b0;
      RESPOND <= 1'b0;
    end else begin
      EXECUTE <= good && (own_hit || (grp_hit &&
                 FRAME.func == grp_mon_pkg::FC_WRITE_MULTI));
      RESPOND <= good && own_hit;
    end
  end

  // Group pair: high half staged, taken with low half; RAM only
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      group_q    <= grp_mon_pkg::GROUP_NONE;
      hi_stage_q <= 16'h0000;
      REG_ERR    <= 1'b0;
    end else begin
      REG_ERR <= 1'b0;
      if (REG_WR && REG_ADDR == grp_mon_pkg::GROUP_HI_OFS)
        hi_stage_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == grp_mon_pkg::GROUP_LO_OFS) begin
        if (grp_new == grp_mon_pkg::GROUP_NONE ||
            (grp_new >= 32'h1 && grp_new <= grp_mon_pkg::GROUP_MAX))
          group_q <= grp_new;
        else
          REG_ERR <= 1'b1;
      end
    end
  end

  // Read mux, reads show held group value
  always_ff @(posedge SYS_CLK) begin
    if (RST)
      REG_RDATA <= 16'h0000;
    else if (REG_ADDR == grp_mon_pkg::GROUP_HI_OFS)
      REG_RDATA <= group_q[31:16];
    else if (REG_ADDR == grp_mon_pkg::GROUP_LO_OFS)
      REG_RDATA <= group_q[15:0];
    else
      REG_RDATA <= 16'h0000;
  end

  // Switch synchroniser; change counts when stages two and three agree
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sw1_q <= 4'h0;
      sw2_q <= 4'h0;
      sw3_q <= 4'h0;
      sw_q  <= 4'h0;
    end else begin
      sw1_q <= BAUD_SELECT_SWITCH;
      sw2_q <= sw1_q;
      sw3_q <= sw2_q;
      if (sw2_q == sw3_q)
        sw_q <= sw3_q;
    end
  end
  assign sw_bad = sw_q >= grp_mon_pkg::BAUD_SEL_BAD;

  // Error code selection for the history
  always_comb begin
    log_en   = 1'b1;
    log_code = grp_mon_pkg::ERR_TRANSMIT;
    if (!bad) begin
      unique case (EXEC_EXC)
        grp_mon_pkg::EXC_UNDEF: log_code = grp_mon_pkg::ERR_UNDEF_CMD;
        grp_mon_pkg::EXC_UI:    log_code = grp_mon_pkg::ERR_UI_BUSY;
        grp_mon_pkg::EXC_NV:    log_code = grp_mon_pkg::ERR_NV_BUSY;
        grp_mon_pkg::EXC_RANGE: log_code = grp_mon_pkg::ERR_RANGE;
        grp_mon_pkg::EXC_DIS:   log_code = grp_mon_pkg::ERR_DISABLED;
        default:                log_en   = 1'b0;
      endcase
    end
  end

  // Volatile history ring, cleared only by reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      hist_wp_q <= 4'h0;
      for (int i = 0; i < grp_mon_pkg::HIST_DEPTH; i++)
        hist_q[i] <= 8'h00;
    end else if (log_en) begin
      hist_q[hist_wp_q] <= log_code;
      hist_wp_q <= hist_wp_q + 4'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST)
      HIST_CODE <= 8'h00;
    else
      HIST_CODE <= hist_q[HIST_IDX];
  end

  // Clamp count to 1..10, read live each cycle
  always_comb begin
    limit = ERR_ALARM_CNT;
    if (limit < grp_mon_pkg::ERR_CNT_MIN)
      limit = grp_mon_pkg::ERR_CNT_MIN;
    if (limit > grp_mon_pkg::ERR_CNT_MAX)
      limit = grp_mon_pkg::ERR_CNT_MAX;
  end

  // Consecutive error run and warning
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      run_q  <= 4'h0;
      warn_q <= 1'b0;
    end else if (bad) begin
      if (run_q != 4'hf)
        run_q <= run_q + 4'h1;
      warn_q <= 1'b1;
    end else if (good) begin
      run_q  <= 4'h0;
      warn_q <= 1'b0;
    end
  end

  // Millisecond tick and idle timer; zero timeout disables
  always_ff @(posedge SYS_CLK) begin
    if (RST || good) begin
      ms_q      <= 24'h0;
      idle_ms_q <= 16'h0;
    end else if (ms_q == 24'(grp_mon_pkg::MS_CYCLES - 1)) begin
      ms_q <= 24'h0;
      if (idle_ms_q != 16'hffff)
        idle_ms_q <= idle_ms_q + 16'h1;
    end else begin
      ms_q <= ms_q + 24'h1;
    end
  end

  // Alarm latch; held until reset, first cause recorded
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      alarm_q      <= 1'b0;
      alarm_code_q <= 8'h00;
    end else if (!alarm_q) begin
      if (run_q >= limit) begin
        alarm_q      <= 1'b1;
        alarm_code_q <= grp_mon_pkg::ERR_TRANSMIT;
      end else if (TIMEOUT_MS != 16'h0 &&
                   TIMEOUT_MS <= grp_mon_pkg::TIMEOUT_MS_MAX &&
                   idle_ms_q >= TIMEOUT_MS) begin
        alarm_q      <= 1'b1;
        alarm_code_q <= grp_mon_pkg::ERR_TIMEOUT;
      end else if (sw_bad) begin
        alarm_q      <= 1'b1;
        alarm_code_q <= 8'h00;
      end
    end
  end

  // Fault, stop, blink and code outputs follow the alarm latch; reset holds fault-free low and stop high; caution follows the warning
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      FAULT_FREE_OUTPUT <= 1'b0;
      MOTOR_STOP        <= 1'b1;
      ALARM_BLINK       <= 1'b0;
      CAUTION_OUTPUT    <= 1'b0;
      ALARM_CODE        <= 8'h00;
    end else begin
      FAULT_FREE_OUTPUT <= !alarm_q;
      MOTOR_STOP        <= alarm_q;
      ALARM_BLINK       <= alarm_q;
      CAUTION_OUTPUT    <= warn_q;
      ALARM_CODE        <= alarm_code_q;
    end
  end

  // Checks; history pointer is looked at one cycle late through $past
  a_child_silent: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    good && !own_hit |=> !RESPOND)
    else $error("child responded");
  a_group_exec: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    good && !own_hit && grp_hit &&
    FRAME.func == grp_mon_pkg::FC_WRITE_MULTI |=> EXECUTE)
    else $error("group query dropped");
  a_parent_exec: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    good && own_hit |=> EXECUTE && RESPOND)
    else $error("own query not answered");
  a_group_func: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    good && !own_hit && FRAME.func != grp_mon_pkg::FC_WRITE_MULTI
    |=> !EXECUTE)
    else $error("bad group function run");
  a_group_range: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    group_q == grp_mon_pkg::GROUP_NONE ||
    (group_q >= 32'h1 && group_q <= grp_mon_pkg::GROUP_MAX))
    else $error("group out of range");
  a_hist_transmit: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    bad |=> hist_q[$past(hist_wp_q)] == grp_mon_pkg::ERR_TRANSMIT &&
    hist_wp_q == $past(hist_wp_q) + 4'h1)
    else $error("transmit error not logged");
  a_hist_exec: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !bad && EXEC_EXC == grp_mon_pkg::EXC_DIS
    |=> hist_q[$past(hist_wp_q)] == grp_mon_pkg::ERR_DISABLED)
    else $error("exception not logged");
  a_warn_set: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    bad |=> ##1 CAUTION_OUTPUT)
    else $error("no warning");
  a_warn_clear: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    good |=> ##1 !CAUTION_OUTPUT)
    else $error("warning stuck");
  a_run_reset: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    good |=> run_q == 4'h0)
    else $error("run not reset");
  a_alarm_outs: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    $rose(alarm_q) |=> !FAULT_FREE_OUTPUT && MOTOR_STOP && ALARM_BLINK)
    else $error("alarm outputs split");
  a_run_alarm: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    run_q >= limit |=> alarm_q)
    else $error("run alarm missed");
  a_switch_alarm: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    sw_bad |=> alarm_q)
    else $error("switch error missed");
  a_idle_alarm: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    TIMEOUT_MS != 16'h0000 && TIMEOUT_MS <= grp_mon_pkg::TIMEOUT_MS_MAX &&
    idle_ms_q >= TIMEOUT_MS |=> alarm_q)
    else $error("timeout alarm missed");
  a_limit_live: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    ERR_ALARM_CNT >= grp_mon_pkg::ERR_CNT_MIN &&
    ERR_ALARM_CNT <= grp_mon_pkg::ERR_CNT_MAX |-> limit == ERR_ALARM_CNT)
    else $error("alarm count not applied");
endmodule
`default_nettype wire

// File: core/grp_mon_pkg.sv
// Package for the serial slave group and error monitor.
// Assumes a frame front end that reports decoded frames and errors.
package grp_mon_pkg;
  // Register offsets of the group address pair
  localparam logic [15:0] GROUP_HI_OFS = 16'h0030;
  localparam logic [15:0] GROUP_LO_OFS = 16'h0031;
  // Group value meaning no group (-1 as a 32-bit pair)
  localparam logic [31:0] GROUP_NONE = 32'hffff_ffff;
  localparam logic [31:0] GROUP_MAX  = 32'h0000_001f;
  // Function code accepted in group reception
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  // Error codes; all but 85h are logged in the history, 85h is an alarm code only
  localparam logic [7:0] ERR_TRANSMIT  = 8'h84;
  localparam logic [7:0] ERR_TIMEOUT   = 8'h85;
  localparam logic [7:0] ERR_UNDEF_CMD = 8'h88;
  localparam logic [7:0] ERR_UI_BUSY   = 8'h89;
  localparam logic [7:0] ERR_NV_BUSY   = 8'h8a;
  localparam logic [7:0] ERR_RANGE     = 8'h8c;
  localparam logic [7:0] ERR_DISABLED  = 8'h8d;
  // Parameter limits and reset values
  localparam logic [15:0] TIMEOUT_MS_MAX  = 16'h2710;
  localparam logic [3:0]  ERR_CNT_MIN     = 4'h1;
  localparam logic [3:0]  ERR_CNT_MAX     = 4'ha;
  localparam logic [3:0]  ERR_CNT_RESET   = 4'h3;
  localparam logic [15:0] TIMEOUT_RESET   = 16'h0000;
  localparam logic [3:0]  BAUD_SEL_BAD    = 4'h8;
  // Timing: 1 ms at 10 MHz
  localparam int unsigned CLK_HZ      = 10000000;
  localparam int unsigned MS_UNIT     = 1000;
  localparam int unsigned MS_CYCLES   = CLK_HZ / MS_UNIT;
  localparam int          HIST_DEPTH  = 16;
  // Frame report from the link front end
  typedef struct packed {
    logic        valid;
    logic        crc_ok;
    logic [7:0]  addr;
    logic [7:0]  func;
  } frame_t;
  // Exception kinds from the command executor
  typedef enum logic [2:0] {
    EXC_NONE = 3'h0, EXC_UNDEF = 3'h1, EXC_UI = 3'h2,
    EXC_NV = 3'h3, EXC_RANGE = 3'h4, EXC_DIS = 3'h5
  } exc_t;
endpackage

// File: testbench/master_model.sv
// Bus master model: frame reports and group register writes.
// Assumes one clock shared with the slave; drives on rising edges.
`timescale 1ns/1ps
`default_nettype none
module master_model (
  // Clock
  input  wire logic              SYS_CLK,
  // Requests toward the slave
  output var grp_mon_pkg::frame_t FRAME,
  output logic                   REG_WR,
  output logic [15:0]            REG_ADDR,
  output logic [15:0]            REG_WDATA
);
  // Idle bus at time zero
  initial begin
    FRAME = '0;
    REG_WR = 1'b0;
    REG_ADDR = 16'h0000;
    REG_WDATA = 16'h0000;
  end

  // One frame; stale fields flip so the slave cannot lean on them
  task automatic send(input logic ok, input logic [7:0] a,
                      input logic [7:0] f);
    @(posedge SYS_CLK);
    FRAME <= {1'b1, ok, a, f};
    @(posedge SYS_CLK);
    FRAME <= {1'b0, ~ok, ~a, ~f};
  endtask

  // Unicast pair write, high half then low half back to back
  task automatic write_group(input logic [31:0] v);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= grp_mon_pkg::GROUP_HI_OFS;
    REG_WDATA <= v[31:16];
    @(posedge SYS_CLK);
    REG_ADDR <= grp_mon_pkg::GROUP_LO_OFS;
    REG_WDATA <= v[15:0];
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    REG_WDATA <= ~v[15:0];
  endtask

  // Select a register for reading
  task automatic point(input logic [15:0] a);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
  endtask
endmodule
`default_nettype wire

// File: testbench/test_grp_mon.sv
// Self-checking bench for the group filter and error monitor.
// Assumes master_model drives frames and register writes.
`timescale 1ns/1ps
`default_nettype none
module test_grp_mon;
  logic                SYS_CLK, RST, REG_WR, REG_ERR, EXECUTE, RESPOND;
  logic                FAULT_FREE_OUTPUT, CAUTION_OUTPUT;
  logic                MOTOR_STOP, ALARM_BLINK, seen;
  grp_mon_pkg::frame_t FRAME;
  grp_mon_pkg::exc_t   EXEC_EXC;
  logic [7:0]          OWN_ADDR, HIST_CODE, ALARM_CODE;
  logic [15:0]         REG_ADDR, REG_WDATA, REG_RDATA, TIMEOUT_MS;
  logic [3:0]          ERR_ALARM_CNT, HIST_IDX, BAUD_SELECT_SWITCH;
  logic [31:0]         seed;
  logic [1:0]          expq[$];
  logic [7:0]          codes[6] = '{8'h84, 8'h88, 8'h89, 8'h8a, 8'h8c, 8'h8d};
  int                  error_cnt, samples_checked, cycles;

  grp_mon uut (.SYS_CLK, .RST, .FRAME, .OWN_ADDR, .EXEC_EXC, .REG_WR,
    .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_ERR, .TIMEOUT_MS,
    .ERR_ALARM_CNT, .HIST_IDX, .HIST_CODE, .BAUD_SELECT_SWITCH, .EXECUTE,
    .RESPOND, .FAULT_FREE_OUTPUT, .CAUTION_OUTPUT, .MOTOR_STOP,
    .ALARM_BLINK, .ALARM_CODE);
  master_model mm (.SYS_CLK, .FRAME, .REG_WR, .REG_ADDR, .REG_WDATA);

  // 100 ns clock
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Decision lands one cycle after each frame report
  always @(posedge SYS_CLK) begin
    seen <= FRAME.valid;
    cycles++;
    if (seen) begin
      chk("exec_resp", {14'h0, expq[0]}, {14'h0, EXECUTE, RESPOND});
      void'(expq.pop_front());
    end
    if (cycles == 40000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic rst();
    @(posedge SYS_CLK);
    RST <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    cyc(3);
  endtask

  task automatic frm(input logic ok, input logic [7:0] a,
                     input logic [7:0] f, input logic [1:0] e);
    expq.push_back(e);
    mm.send(ok, a, f);
  endtask

  // Alarm state: fault-free low, stop and blink high together
  task automatic alarm(input logic a, input logic [7:0] c);
    chk("alarm", {5'h0, ~a, a, a, c},
        {5'h0, FAULT_FREE_OUTPUT, MOTOR_STOP, ALARM_BLINK, ALARM_CODE});
  endtask

  initial begin
    RST = 1'b1;
    OWN_ADDR = 8'h07;
    EXEC_EXC = grp_mon_pkg::EXC_NONE;
    TIMEOUT_MS = 16'h0000;
    ERR_ALARM_CNT = 4'h2;
    HIST_IDX = 4'h0;
    BAUD_SELECT_SWITCH = 4'h2;
    seed = 32'h6b5f;
    rst();
    alarm(1'b0, 8'h00);
    mm.point(grp_mon_pkg::GROUP_HI_OFS);
    cyc(2);
    chk("grp_hi", 16'hffff, REG_RDATA);
    // Parent, no-group and child reception
    frm(1'b1, OWN_ADDR, 8'h10, 2'b11);
    frm(1'b1, 8'h05, 8'h10, 2'b00);
    mm.write_group(32'h0000_0005);
    frm(1'b1, 8'h05, 8'h10, 2'b10);
    seed = lfsr(seed);
    frm(1'b1, 8'h05, (seed[7:0] == 8'h10) ? 8'h03 : seed[7:0], 2'b00);
    mm.write_group(32'h0000_0020);
    #1 chk("reg_err", 16'h0001, {15'h0, REG_ERR});
    mm.point(grp_mon_pkg::GROUP_LO_OFS);
    cyc(2);
    chk("grp_lo", 16'h0005, REG_RDATA);
    $display("group test done");
    // Warning, then every history code
    frm(1'b0, OWN_ADDR, 8'h10, 2'b00);
    cyc(2);
    chk("caution", 16'h0001, {15'h0, CAUTION_OUTPUT});
    for (int i = 1; i < 6; i++) begin
      @(posedge SYS_CLK);
      EXEC_EXC <= grp_mon_pkg::exc_t'(i);
      @(posedge SYS_CLK);
      EXEC_EXC <= grp_mon_pkg::EXC_NONE;
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge SYS_CLK);
      HIST_IDX <= 4'(i);
      cyc(2);
      chk("hist", {8'h0, codes[i]}, {8'h0, HIST_CODE});
    end
    frm(1'b1, OWN_ADDR, 8'h03, 2'b11);
    cyc(2);
    chk("caution", 16'h0000, {15'h0, CAUTION_OUTPUT});
    // Broken run, then an unbroken one
    frm(1'b0, OWN_ADDR, 8'h10, 2'b00);
    frm(1'b1, OWN_ADDR, 8'h10, 2'b11);
    frm(1'b0, OWN_ADDR, 8'h10, 2'b00);
    cyc(4);
    alarm(1'b0, 8'h00);
    frm(1'b0, OWN_ADDR, 8'h10, 2'b00);
    cyc(4);
    alarm(1'b1, 8'h84);
    $display("error test done");
    // Silence past a 1 ms limit
    rst();
    TIMEOUT_MS <= 16'h0001;
    frm(1'b1, OWN_ADDR, 8'h10, 2'b11);
    cyc(9000);
    alarm(1'b0, 8'h00);
    cyc(2000);
    alarm(1'b1, 8'h85);
    TIMEOUT_MS <= 16'h0000;
    // A count of zero clamps to one, so one bad frame alarms at once
    rst();
    ERR_ALARM_CNT <= 4'h0;
    frm(1'b0, OWN_ADDR, 8'h10, 2'b00);
    cyc(4);
    alarm(1'b1, 8'h84);
    rst();
    seed = lfsr(seed);
    @(posedge SYS_CLK);
    BAUD_SELECT_SWITCH <= {1'b1, seed[2:0]};
    cyc(8);
    alarm(1'b1, 8'h00);
    $display("alarm test done");
    final_report();
  end
endmodule
`default_nettype wire
